// ---- design/tcou_top.sv ----
// Timer compare output unit with APB register access.
//
// Local design decisions: the address map and the APB register port.
`include "tcou_cfg.svh"
module tcou_top (
  input wire logic pclk, // Bus and timer clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [1:0] port_data, // Port data per pin
  input wire logic [1:0] port_dir, // Pin direction, 1 output
  output logic [1:0] pin_out, // Pin level
  output logic [1:0] pin_oe, // Pin output enable
  input wire logic [2:0] irq_ack, // Request serviced pulses
  output logic [2:0] irq_req // Interrupt requests
);
  // ==========================================================
  // Register map, one byte-wide register per word
  // 0x00 control A: [7:6] action A, [5:4] action B, [1:0] mode low
  // 0x04 control B: [7:6] force strobes, [3] mode high, [2:0] source
  // 0x08 counter, a write blocks the matches of the next tick
  // 0x0c compare A, 0x10 compare B
  // 0x14 flags: [0] overflow, [1] match A, [2] match B, one clears
  // 0x18 request mask, same bit order as the flags
  // Any other address answers with an error and reads zero
  // Every access is answered in its first access cycle
  // Clock source is only a gate: any nonzero value ticks each clock
  // Modes 4 and 6 count as normal mode
  // PWM toggle only acts on channel A with mode bit 2 set

  // ==========================================================
  // Declarations
  logic [7:0] ctrl_a_r;
  logic [7:0] ctrl_b_r;
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic [2:0] mask_r;
  logic ovf_r;
  logic block_r;
  logic dir_r;
  logic dir_nxt;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [1:0] pin_out_r;
  logic [1:0] pin_oe_r;
  logic [2:0] irq_r;
  tcou_chan_if ch [2] ();
  logic [7:0] cmp_rd [2];
  logic [1:0] flag_v;
  logic [1:0] ocb_v;
  logic [1:0] com_v [2];
  logic [1:0] force_v;
  logic [1:0] cmp_wr_v;
  logic [1:0] tog_v;

  // ==========================================================
  // Bus decode
  logic acc;
  logic wr;
  logic setup;
  logic sel_ctrl_a;
  logic sel_ctrl_b;
  logic sel_count;
  logic sel_cmp_a;
  logic sel_cmp_b;
  logic sel_flags;
  logic sel_mask;
  logic mapped;
  logic [31:0] rd_mux;
  logic [2:0] flag_w1c;

  // Phase and address decode
  assign setup = psel & ~penable;
  assign acc = psel & penable & pready_r;
  assign wr = acc & pwrite & mapped;
  assign sel_ctrl_a = (paddr == `TCOU_OFF_CTRL_A);
  assign sel_ctrl_b = (paddr == `TCOU_OFF_CTRL_B);
  assign sel_count = (paddr == `TCOU_OFF_COUNT);
  assign sel_cmp_a = (paddr == `TCOU_OFF_CMP_A);
  assign sel_cmp_b = (paddr == `TCOU_OFF_CMP_B);
  assign sel_flags = (paddr == `TCOU_OFF_FLAGS);
  assign sel_mask = (paddr == `TCOU_OFF_MASK);
  assign mapped = sel_ctrl_a | sel_ctrl_b | sel_count | sel_cmp_a |
    sel_cmp_b | sel_flags | sel_mask;

  // Read data selection, strobes read as zero
  assign rd_mux =
    sel_ctrl_a ? {24'h000000, ctrl_a_r} :
    sel_ctrl_b ? {24'h000000, 4'h0, ctrl_b_r[3:0]} :
    sel_count ? {24'h000000, count_r} :
    sel_cmp_a ? {24'h000000, cmp_rd[0]} :
    sel_cmp_b ? {24'h000000, cmp_rd[1]} :
    sel_flags ? {29'h00000000, flag_v[1], flag_v[0], ovf_r} :
    sel_mask ? {29'h00000000, mask_r} :
    32'h00000000;

  // Write strobes per stored register
  logic wr_ctrl_a;
  logic wr_ctrl_b;
  logic wr_mask;
  assign wr_ctrl_a = wr & sel_ctrl_a;
  assign wr_ctrl_b = wr & sel_ctrl_b;
  assign wr_mask = wr & sel_mask;

  // ==========================================================
  // Mode decode
  logic [2:0] wgm;
  logic tick;
  logic pwm;
  logic fast;
  logic phase;
  logic clear_on_match_mode;
  logic [7:0] top_val;
  logic at_top;
  logic cnt_wr;
  logic ctc_clr;
  logic ovf_set;

  assign wgm = {ctrl_b_r[`TCOU_BIT_WGM_HI], ctrl_a_r[1:0]};
  assign tick = (ctrl_b_r[2:0] != 3'h0);
  assign pwm = wgm[0];
  assign fast = (wgm[1:0] == 2'h3);
  assign phase = (wgm[1:0] == 2'h1);
  assign clear_on_match_mode = (wgm == tcou_pkg::TCOU_WGM_CTC);
  assign top_val = wgm[2] ? ch[0].cmp_act : `TCOU_CNT_MAX;
  assign at_top = (count_r == top_val);
  assign cnt_wr = wr & sel_count;
  assign ctc_clr = clear_on_match_mode & ch[0].match & ~block_r;

  // Counter and direction next values
  always_comb begin
    count_nxt = count_r;
    dir_nxt = dir_r;
    if (cnt_wr) begin
      count_nxt = pwdata[7:0];
    end else if (tick) begin
      if (fast) begin
        count_nxt = at_top ? `TCOU_CNT_BOTTOM : count_r + 8'h01;
      end else if (phase) begin
        if (dir_r && at_top) begin
          dir_nxt = 1'b0;
          count_nxt = count_r - 8'h01;
        end else if (!dir_r && count_r == `TCOU_CNT_BOTTOM) begin
          dir_nxt = 1'b1;
          count_nxt = count_r + 8'h01;
        end else begin
          count_nxt = dir_r ? count_r + 8'h01 : count_r - 8'h01;
        end
      end else if (ctc_clr) begin
        count_nxt = `TCOU_CNT_BOTTOM;
      end else begin
        count_nxt = count_r + 8'h01;
      end
    end
    if (!phase) begin
      dir_nxt = 1'b1;
    end
  end

  assign ovf_set = tick & ~cnt_wr & (
    fast ? at_top :
    phase ? (~dir_r & (count_r == 8'h01)) :
    (count_r == `TCOU_CNT_MAX) & ~ctc_clr);

  // ==========================================================
  // Channel hookup
  assign com_v[0] = ctrl_a_r[`TCOU_BIT_COM_A +: 2];
  assign com_v[1] = ctrl_a_r[`TCOU_BIT_COM_B +: 2];
  assign force_v[0] = wr & sel_ctrl_b & pwdata[`TCOU_BIT_FOC_A];
  assign force_v[1] = wr & sel_ctrl_b & pwdata[`TCOU_BIT_FOC_B];
  assign cmp_wr_v[0] = wr & sel_cmp_a;
  assign cmp_wr_v[1] = wr & sel_cmp_b;
  assign tog_v[0] = wgm[2];
  assign tog_v[1] = 1'b0;
  assign flag_w1c = (wr & sel_flags) ? pwdata[2:0] : 3'h0;

  // Per channel wiring and instance
  for (genvar g = 0; g < 2; g++) begin : g_chan
    assign ch[g].cnt = count_r;
    assign ch[g].tick = tick;
    assign ch[g].block = block_r;
    assign ch[g].pwm = pwm;
    assign ch[g].fast = fast;
    assign ch[g].phase = phase;
    assign ch[g].up = dir_r;
    assign ch[g].load = pwm & tick & at_top;
    assign ch[g].bot_evt = fast & tick & at_top;
    assign ch[g].tog_ok = tog_v[g];
    assign ch[g].com = tcou_pkg::tcou_com_t'(com_v[g]);
    assign ch[g].wr_en = cmp_wr_v[g];
    assign ch[g].wdata = pwdata[7:0];
    assign ch[g].force_req = force_v[g];
    assign ch[g].flag_clr = flag_w1c[g + 1] | irq_ack[g + 1];
    assign cmp_rd[g] = ch[g].cmp_rd;
    assign flag_v[g] = ch[g].flag;
    assign ocb_v[g] = ch[g].ocb;
    tcou_cmp_chan u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .ch(ch[g])
    );
  end

  // ==========================================================
  // Registers
  // Control A: actions and low mode bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_r <= `TCOU_RST_BYTE;
    end else if (wr_ctrl_a) begin
      ctrl_a_r <= {pwdata[7:4], 2'h0, pwdata[1:0]};
    end
  end

  // Control B: strobes are not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_b_r <= `TCOU_RST_BYTE;
    end else if (wr_ctrl_b) begin
      ctrl_b_r <= {4'h0, pwdata[3:0]};
    end
  end

  // Request mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= 3'h0;
    end else if (wr_mask) begin
      mask_r <= pwdata[2:0];
    end
  end

  // Counter value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= `TCOU_CNT_BOTTOM;
    end else begin
      count_r <= count_nxt;
    end
  end

  // Count direction, up after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_r <= 1'b1;
    end else begin
      dir_r <= dir_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_r <= 1'b0;
    end else if (cnt_wr) begin
      block_r <= 1'b1;
    end else if (tick) begin
      block_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_r <= 1'b0;
    end else begin
      ovf_r <= ovf_set | (ovf_r & ~(flag_w1c[0] | irq_ack[0]));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 3'h0;
    end else begin
      irq_r <= {flag_v[1], flag_v[0], ovf_r} & mask_r & ~irq_ack;
    end
  end

  // APB ready, one access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= setup;
    end
  end

  // APB error for unmapped addresses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= setup & ~mapped;
    end
  end

  // APB read data, taken at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else if (setup) begin
      prdata_r <= pwrite ? 32'h00000000 : rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_r <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        pin_out_r[i] <= (com_v[i] != 2'h0) ? ocb_v[i] : port_data[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_oe_r <= 2'h0;
    end else begin
      pin_oe_r <= port_dir;
    end
  end

  // Output drive
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign pin_out = pin_out_r;
  assign pin_oe = pin_oe_r;
  assign irq_req = irq_r;
endmodule // tcou_top

// ---- design/tcou_cfg.svh ----
// Constants for the timer compare output unit.
// Function
// - Compare the 8-bit counter with both compare values every timer clock.
// - Set a channel's compare flag one timer clock after the match.
// - Enabled flags raise interrupt requests; servicing a request clears its flag.
// - Writing one to a flag bit clears it; writing zero keeps it.
// - PWM modes double buffer compare values, loaded at top.
// - CPU reaches the buffer when buffering, else the active value.
// - Force strobe in non-PWM modes acts as a match, without flag or clear.
// - Any counter write blocks compare matches for the next timer clock.
// - The output bit keeps its value across waveform mode changes.
// - Output action settings apply at once, from the next match.
// - Nonzero output action drives the pin from the output bit.
// - Pin direction stays under port direction control.
// - Output action zero never changes the output bit.
// - Non-PWM set/clear/toggle; PWM inverted or non-inverted output.
// - Normal mode counts up only, wrapping 0xff to 0x00.
// - Normal mode overflow flag sets as the counter becomes zero.
// - Clear-on-match mode clears the counter at compare value A.
// - A CPU counter write beats any clear or count.
// - Clock source select zero stops counting; counter stays accessible.
// - Waveform mode is two bits of control A plus one of control B.
// - Clear-on-match mode overflow flag sets on rollover from 0xff.
`ifndef TCOU_CFG_SVH
`define TCOU_CFG_SVH
`define TCOU_OFF_CTRL_A 8'h00
`define TCOU_OFF_CTRL_B 8'h04
`define TCOU_OFF_COUNT 8'h08
`define TCOU_OFF_CMP_A 8'h0c
`define TCOU_OFF_CMP_B 8'h10
`define TCOU_OFF_FLAGS 8'h14
`define TCOU_OFF_MASK 8'h18
`define TCOU_BIT_COM_A 6
`define TCOU_BIT_COM_B 4
`define TCOU_BIT_FOC_A 7
`define TCOU_BIT_FOC_B 6
`define TCOU_BIT_WGM_HI 3
`define TCOU_BIT_OVF 0
`define TCOU_BIT_FLAG_A 1
`define TCOU_BIT_FLAG_B 2
`define TCOU_RST_BYTE 8'h00
`define TCOU_CNT_MAX 8'hff
`define TCOU_CNT_BOTTOM 8'h00
`endif

// ---- design/tcou_pkg.sv ----
// Types shared by the timer compare output unit.
package tcou_pkg;
  // Waveform modes
  typedef enum logic [2:0] {
    TCOU_WGM_NORMAL = 3'h0,
    TCOU_WGM_PC_FF = 3'h1,
    TCOU_WGM_CTC = 3'h2,
    TCOU_WGM_FAST_FF = 3'h3,
    TCOU_WGM_PC_A = 3'h5,
    TCOU_WGM_FAST_A = 3'h7
  } tcou_wgm_t;
  // Output action codes
  typedef enum logic [1:0] {
    TCOU_COM_NONE = 2'h0,
    TCOU_COM_TOGGLE = 2'h1,
    TCOU_COM_CLEAR = 2'h2,
    TCOU_COM_SET = 2'h3
  } tcou_com_t;
endpackage : tcou_pkg

// ---- design/tcou_chan_if.sv ----
// Signals between the timer core and one compare channel.
interface tcou_chan_if;
  logic [7:0] cnt;
  logic tick;
  logic block;
  logic pwm;
  logic fast;
  logic phase;
  logic up;
  logic load;
  logic bot_evt;
  logic tog_ok;
  tcou_pkg::tcou_com_t com;
  logic wr_en;
  logic [7:0] wdata;
  logic force_req;
  logic flag_clr;
  logic [7:0] cmp_rd;
  logic [7:0] cmp_act;
  logic match;
  logic flag;
  logic ocb;
  modport core (output cnt, tick, block, pwm, fast, phase, up, load,
    bot_evt, tog_ok, com, wr_en, wdata, force_req, flag_clr,
    input cmp_rd, cmp_act, match, flag, ocb);
  modport chan (input cnt, tick, block, pwm, fast, phase, up, load,
    bot_evt, tog_ok, com, wr_en, wdata, force_req, flag_clr,
    output cmp_rd, cmp_act, match, flag, ocb);
endinterface : tcou_chan_if

// ---- design/tcou_cmp_chan.sv ----
// One compare channel: buffer, comparator, flag and output bit.
`include "tcou_cfg.svh"
module tcou_cmp_chan (
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, active low
  tcou_chan_if.chan ch // Core connection
);
  logic [7:0] buf_r;
  logic [7:0] act_r;
  logic flag_r;
  logic ocb_r;
  logic ocb_nxt;
  logic hit;
  logic do_act;
  assign ch.match = (ch.cnt == act_r);
  assign hit = ch.tick & ch.match & ~ch.block;
  assign do_act = hit | (ch.force_req & ~ch.pwm);
  // CPU sees buffer or active value
  assign ch.cmp_rd = ch.pwm ? buf_r : act_r;
  assign ch.cmp_act = act_r;
  assign ch.flag = flag_r;
  assign ch.ocb = ocb_r;
  // Output bit next value
  always_comb begin
    ocb_nxt = ocb_r;
    if (!ch.pwm) begin
      if (do_act) begin
        case (ch.com)
          tcou_pkg::TCOU_COM_TOGGLE: ocb_nxt = ~ocb_r;
          tcou_pkg::TCOU_COM_CLEAR: ocb_nxt = 1'b0;
          tcou_pkg::TCOU_COM_SET: ocb_nxt = 1'b1;
          default: ocb_nxt = ocb_r;
        endcase
      end
    end else if (hit) begin
      case (ch.com)
        tcou_pkg::TCOU_COM_TOGGLE: ocb_nxt = ch.tog_ok ? ~ocb_r : ocb_r;
        tcou_pkg::TCOU_COM_CLEAR: ocb_nxt = ch.phase & ~ch.up;
        tcou_pkg::TCOU_COM_SET: ocb_nxt = ~(ch.phase & ~ch.up);
        default: ocb_nxt = ocb_r;
      endcase
    end else if (ch.bot_evt) begin
      case (ch.com)
        tcou_pkg::TCOU_COM_CLEAR: ocb_nxt = 1'b1;
        tcou_pkg::TCOU_COM_SET: ocb_nxt = 1'b0;
        default: ocb_nxt = ocb_r;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_r <= `TCOU_RST_BYTE;
      act_r <= `TCOU_RST_BYTE;
    end else begin
      if (ch.wr_en) begin
        buf_r <= ch.wdata;
      end
      if (ch.wr_en && !ch.pwm) begin
        act_r <= ch.wdata;
      end else if (ch.load) begin
        act_r <= buf_r;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= hit | (flag_r & ~ch.flag_clr);
    end
  end
  // output bit only moves on actions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ocb_r <= 1'b0;
    end else begin
      ocb_r <= ocb_nxt;
    end
  end
endmodule // tcou_cmp_chan

// ---- testbench/tcou_sva.sv ----
// Port-level checker for the compare output unit.
// =====================================================
// Checker
module tcou_sva (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Write
  input wire logic [7:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic [1:0] port_data, // Port data
  input wire logic [1:0] port_dir, // Direction
  input wire logic [1:0] pin_out, // Pin level
  input wire logic [1:0] pin_oe, // Pin enable
  input wire logic [2:0] irq_ack, // Service
  input wire logic [2:0] irq_req // Requests
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] com_r; // Shadow of both actions
  logic [2:0] msk_r; // Shadow of the mask
  wire wr_done = psel && penable && pready && pwrite;
  // Shadow copies follow completed writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      com_r <= 4'h0;
      msk_r <= 3'h0;
    end else begin
      if (wr_done && paddr == 8'h00) com_r <= pwdata[7:4];
      if (wr_done && paddr == 8'h18) msk_r <= pwdata[2:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_unmapped_err: assert property (psel && !penable &&
    (paddr > 8'h18 || paddr[1:0] != 2'h0) |=> pslverr)
    else $error("unmapped access not refused");
  a_read_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0
    && (!pwrite || prdata[7:0] == 8'h00))
    else $error("read data upper bits set");
  a_oe_follows_dir: assert property (pin_oe == $past(port_dir))
    else $error("pin enable not from direction");
  a_pin_port_a: assert property ($past(com_r[3:2]) == 2'h0 |->
    pin_out[0] == $past(port_data[0]))
    else $error("pin a not port data");
  a_pin_port_b: assert property ($past(com_r[1:0]) == 2'h0 |->
    pin_out[1] == $past(port_data[1]))
    else $error("pin b not port data");
  a_irq_masked: assert property ((irq_req & ~$past(msk_r)) == 3'h0)
    else $error("request while masked");
  a_ack_drops_req: assert property (|irq_ack |=>
    (irq_req & $past(irq_ack)) == 3'h0)
    else $error("request after service");
endmodule // tcou_sva
bind tcou_top tcou_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .port_data, .port_dir,
  .pin_out, .pin_oe, .irq_ack, .irq_req);

// ---- testbench/tcou_cpu_model.sv ----
// Interrupt service side of the CPU.
// =====================================================
// Service model
module tcou_cpu_model (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic svc_en, // Servicing allowed
  input wire logic [2:0] irq_req, // Requests
  output logic [2:0] irq_ack // Service pulses
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_ack <= 3'h0;
    else irq_ack <= irq_req & ~irq_ack & {3{svc_en}};
  end
endmodule // tcou_cpu_model

// ---- testbench/tcou_tb_top.sv ----
// Self-checking bench for the compare output unit.
// =====================================================
// Bench top
module timer_compare_output_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, svc_en, es;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr;
  logic [1:0] port_data, port_dir, pin_out, pin_oe;
  logic [2:0] irq_ack, irq_req;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int eff, cnt, ca, cb, oa, ob, fl, msk, md, ta, tx, k, n, t0;
  tcou_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .port_data, .port_dir,
    .pin_out, .pin_oe, .irq_ack, .irq_req);
  tcou_cpu_model cpu (.pclk, .presetn, .svc_en, .irq_req, .irq_ack);
  // Clock and cycle count
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;
  task automatic wrap_up();
    $display("TB counts: %0d compares, %0d errors", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer, bounded wait on pready
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
    output logic [31:0] r);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      err_count++;
      wrap_up();
    end
    r = prdata;
    es = pslverr;
    eff = cyc;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(logic [7:0] a, int d);
    logic [31:0] r;
    apb(1'b1, a, 32'(d), r);
  endtask
  task automatic rdc(string nm, logic [7:0] a, int exp);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    check(nm, r, exp);
  endtask
  function automatic int act(int c, int o);
    return c == 1 ? 1 - o : c == 2 ? 0 : c == 3 ? 1 : o;
  endfunction
  // Counter, flags and output bits over n ticks, first tick blocked
  task automatic model(int n);
    for (int i = 1; i <= n; i++) begin
      if (i > 1 && cnt == ca) begin
        fl |= 2;
        oa = act(ta, oa);
      end
      if (i > 1 && cnt == cb) begin
        fl |= 4;
        ob = act(tx, ob);
      end
      if (md == 2 && cnt == ca) cnt = 0;
      else begin
        if (cnt == 255) fl |= 1;
        cnt = (cnt + 1) % 256;
      end
    end
  endtask
  // Main sequence
  initial begin
    logic [31:0] r;
    {psel, penable, pwrite, svc_en, presetn} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    port_data = 2'h0;
    port_dir = 2'h0;
    oa = 0;
    ob = 0;
    k = $urandom(86);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, last address unmapped
    for (k = 0; k < 8; k++) begin
      apb(1'b0, 8'(k * 4), 32'h0, r);
      check("reset value", r, 0);
      check("slverr", es, k == 7);
    end
    $display("TB test reset done");
    // Force strobes over every action code
    for (k = 0; k < 6; k++) begin
      ta = k % 4;
      tx = (k + 1) % 4;
      port_data <= 2'($urandom);
      port_dir <= 2'($urandom);
      wr(8'h00, ta * 64 + tx * 16);
      // both output bits follow their action code through the force strobes
      wr(8'h04, 8'hc0);
      oa = act(ta, oa);
      ob = act(tx, ob);
      repeat (2) @(posedge pclk);
      check("pin a", pin_out[0], ta ? oa : port_data[0]);
      check("pin b", pin_out[1], tx ? ob : port_data[1]);
      check("pin oe", pin_oe, port_dir);
      rdc("flags", 8'h14, 0);
    end
    wr(8'h04, 8'h08);
    wr(8'h00, ta * 64 + tx * 16 + 2);
    check("pins kept", pin_out, {ob[0], oa[0]});
    // Fast PWM: compare writes reach the buffer only
    wr(8'h04, 8'h00);
    wr(8'h00, ta * 64 + tx * 16 + 3);
    cb = $urandom % 256;
    wr(8'h10, cb);
    rdc("pwm buffer", 8'h10, cb);
    check("pins pwm", pin_out, {ob[0], oa[0]});
    wr(8'h00, ta * 64 + tx * 16);
    rdc("active kept", 8'h10, 0);
    $display("TB test force done");
    // Timed runs in normal and clear-on-match modes
    for (k = 0; k < 6; k++) begin
      md = k % 2 * 2;
      cnt = $urandom % 256;
      ca = k == 0 ? cnt : $urandom % 200;
      if (md == 2 && ca == cnt) ca = (cnt + 1) % 200;
      cb = $urandom % 256;
      ta = 1 + $urandom % 3;
      tx = 1 + $urandom % 3;
      msk = $urandom % 8;
      fl = 0;
      wr(8'h00, ta * 64 + tx * 16 + md);
      wr(8'h0c, ca);
      wr(8'h10, cb);
      wr(8'h18, msk);
      wr(8'h08, cnt);
      wr(8'h04, 1);
      t0 = eff;
      repeat ($urandom % 300) @(posedge pclk);
      wr(8'h04, 0);
      n = eff - t0;
      model(n);
      rdc("count", 8'h08, cnt);
      rdc("flags", 8'h14, fl);
      rdc("cmp a", 8'h0c, ca);
      check("pins", pin_out, {ob[0], oa[0]});
      check("irq", irq_req, fl & msk);
      svc_en <= 1'b1;
      repeat (4) @(posedge pclk);
      svc_en <= 1'b0;
      fl &= ~msk;
      rdc("serviced", 8'h14, fl);
      wr(8'h14, 0);
      rdc("kept", 8'h14, fl);
      wr(8'h14, 7);
      rdc("cleared", 8'h14, 0);
      $display("TB test run %0d done", k);
    end
    wrap_up();
  end
endmodule // timer_compare_output_unit_tb_top
